// ---- fst_pkg.sv ----
/*
  constants, field layout and carrier types of the fuse timing and
  supply monitor configuration block.
  assumes a 50 mhz peripheral clock and an avalon-mm slave port with
  32-bit data and byte enables.
*/
package fst_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned FST_CLK_PERIOD_NS = 20;
  localparam int unsigned FST_MIN_PHASE_NS  = 100;
  // a count n gives n+1 periods, so the least safe count rounds up then drops one
  localparam int unsigned FST_MIN_PHASE_CYC = (FST_MIN_PHASE_NS + FST_CLK_PERIOD_NS - 1) / FST_CLK_PERIOD_NS;
  localparam logic [7:0]  FST_COUNT_RST     = 8'(FST_MIN_PHASE_CYC - 1);

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] FST_OFS_TIMING   = 8'h00;
  localparam logic [7:0] FST_OFS_SUPPLY   = 8'h1c;
  localparam logic [1:0] FST_WIN_TAG      = 2'h2;   // address[7:6] of 0x80..0xbf

  // efuse_timing_ctrl fields
  localparam int unsigned FST_TIM_STROBE_LSB = 0;
  localparam int unsigned FST_TIM_HOLD_LSB   = 8;
  localparam int unsigned FST_TIM_SETUP_LSB  = 16;

  // supply_monitor_cfg fields
  localparam int unsigned FST_CFG_THR_LSB    = 0;
  localparam int unsigned FST_CFG_DET_EN     = 2;
  localparam int unsigned FST_CFG_IRQ_EN     = 3;
  localparam int unsigned FST_CFG_RST_EN     = 4;
  localparam int unsigned FST_CFG_OUT_EN     = 5;
  localparam int unsigned FST_CFG_KEY_LSB    = 6;
  localparam int unsigned FST_CFG_POR_EN     = 8;
  localparam int unsigned FST_CFG_FLAG       = 15;

  // unlock key codes
  localparam logic [1:0] FST_KEY_STEP1  = 2'h1;
  localparam logic [1:0] FST_KEY_STEP2  = 2'h2;
  localparam logic [1:0] FST_KEY_OPEN   = 2'h3;
  localparam logic [1:0] FST_KEY_RELOCK = 2'h0;

  // avalon response codes
  localparam logic [1:0] FST_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FST_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    FST_RD_IDLE   = 5'h01,
    FST_RD_SETUP  = 5'h02,
    FST_RD_STROBE = 5'h04,
    FST_RD_HOLD   = 5'h08,
    FST_RD_DONE   = 5'h10
  } fst_rd_state_t;

  typedef enum logic [3:0] {
    FST_KEY_LOCKED = 4'h1,
    FST_KEY_SAW1   = 4'h2,
    FST_KEY_SAW2   = 4'h4,
    FST_KEY_UNLOCK = 4'h8
  } fst_key_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } fst_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic [1:0]  response;
    logic        waitrequest;
  } fst_avm_rsp_t;

  typedef struct packed {
    logic [5:0] fuse_addr;
    logic       fuse_read_enable;
    logic       fuse_strobe;
  } fst_fuse_req_t;

  typedef struct packed {
    logic       erased;
    logic [1:0] threshold;
    logic       reset_enable;
    logic       por_enable;
  } fst_fuse_dflt_t;

endpackage : fst_pkg

// ---- fst_ctrl.sv ----
/*
  fuse read sequencer, fuse read data register and key-protected
  supply monitor configuration behind an avalon-mm slave.
  assumes fuse_dout_i and fuse_dflt_i are on clk_i and stable, and
  monitored_supply_below_i comes from an analog comparator.
*/
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
module fst_ctrl (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire fst_pkg::fst_avm_req_t  avm_req_i,
  input  wire logic                   supervisor_i,
  output fst_pkg::fst_avm_rsp_t       avm_rsp_o,
  output fst_pkg::fst_fuse_req_t      fuse_req_o,
  input  wire logic [7:0]             fuse_dout_i,
  input  wire fst_pkg::fst_fuse_dflt_t fuse_dflt_i,
  input  wire logic                   monitored_supply_below_i,
  output logic [1:0]                  threshold_sel_o,
  output logic [3:0]                  threshold_level_o,
  output logic                        detector_enable_o,
  output logic                        detector_out_o,
  output logic                        detector_out_oe_o,
  output logic                        low_supply_irq_o,
  output logic                        por_request_o,
  output logic                        supply_reset_request_o
);
  import fst_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic           ack, next_ack;
  logic [31:0]    rdata, next_rdata;
  logic [1:0]     resp, next_resp;
  logic           start_fuse;
  logic           wr_ok;
  logic           in_window;
  logic [1:0]     lane;
  logic [31:0]    reg_rd;
  logic [15:0]    cfg_rd;

  fst_rd_state_t  rd_state, next_rd_state;
  logic [7:0]     rd_cnt, next_rd_cnt;
  logic [5:0]     fuse_addr, next_fuse_addr;
  logic           fuse_fuse_read_enable, next_fuse_fuse_read_enable;
  logic           fuse_strb, next_fuse_strb;
  logic [7:0]     read_data, next_read_data;

  logic [7:0]     strobe_cnt, next_strobe_cnt;
  logic [7:0]     hold_cnt, next_hold_cnt;
  logic [7:0]     setup_cnt, next_setup_cnt;

  fst_key_state_t key_state, next_key_state;
  logic [1:0]     thr, next_thr;
  logic           det_en, next_det_en;
  logic           irq_en, next_irq_en;
  logic           rst_en, next_rst_en;
  logic           out_en, next_out_en;
  logic           por_en, next_por_en;
  logic           flag, next_flag;
  logic           load_pending, next_load_pending;
  logic           irq, next_irq;
  logic           por_req, next_por_req;
  logic           rst_req, next_rst_req;
  logic           det_out, next_det_out;
  logic           below_meta, below_s;
  logic [1:0]     key_wr;

  // ----------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      below_meta <= 1'b0;
      below_s    <= 1'b0;
    end else begin
      below_meta <= monitored_supply_below_i;
      below_s    <= below_meta;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign in_window = (avm_req_i.address[7:6] == FST_WIN_TAG);
  // fuse byte sits in the lowest enabled lane
  assign lane = avm_req_i.byteenable[0] ? 2'h0 :
                avm_req_i.byteenable[1] ? 2'h1 :
                avm_req_i.byteenable[2] ? 2'h2 : 2'h3;
  assign wr_ok = avm_req_i.write && ack && (resp == FST_RESP_OKAY);
  assign key_wr = avm_req_i.writedata[FST_CFG_KEY_LSB +: 2];

  always_comb begin
    cfg_rd = 16'h0000;
    cfg_rd[FST_CFG_THR_LSB +: 2] = thr;
    cfg_rd[FST_CFG_DET_EN]       = det_en;
    cfg_rd[FST_CFG_IRQ_EN]       = irq_en;
    cfg_rd[FST_CFG_RST_EN]       = rst_en;
    cfg_rd[FST_CFG_OUT_EN]       = out_en;
    cfg_rd[FST_CFG_KEY_LSB +: 2] = (key_state == FST_KEY_UNLOCK) ? FST_KEY_OPEN : FST_KEY_RELOCK;
    cfg_rd[FST_CFG_POR_EN]       = por_en;
    cfg_rd[FST_CFG_FLAG]         = flag;
    case (avm_req_i.address)
      FST_OFS_TIMING: reg_rd = {8'h00, setup_cnt, hold_cnt, strobe_cnt};
      FST_OFS_SUPPLY: reg_rd = {16'h0000, cfg_rd};
      default:        reg_rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_comb begin
    next_ack   = 1'b0;
    next_rdata = rdata;
    next_resp  = resp;
    start_fuse = 1'b0;
    if ((avm_req_i.read || avm_req_i.write) && !ack) begin
      if (!supervisor_i) begin
        next_ack   = 1'b1;
        next_rdata = 32'h0000_0000;
        next_resp  = FST_RESP_SLVERR;
      end else if (avm_req_i.read && in_window) begin
        start_fuse = (rd_state == FST_RD_IDLE);
        if (rd_state == FST_RD_DONE) begin
          next_ack   = 1'b1;
          next_rdata = {4{read_data}};
          next_resp  = FST_RESP_OKAY;
        end
      end else begin
        next_ack   = 1'b1;
        next_rdata = avm_req_i.read ? reg_rd : 32'h0000_0000;
        next_resp  = FST_RESP_OKAY;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
      resp  <= FST_RESP_OKAY;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
      resp  <= next_resp;
    end
  end

  assign avm_rsp_o = '{readdata: rdata, response: resp,
                       waitrequest: (avm_req_i.read || avm_req_i.write) && !ack};

  // ----------------------------------------------------------------
  // fuse read sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_rd_state  = rd_state;
    next_rd_cnt    = rd_cnt;
    next_fuse_addr = fuse_addr;
    next_fuse_fuse_read_enable = fuse_fuse_read_enable;
    next_fuse_strb = fuse_strb;
    next_read_data = read_data;
    case (rd_state)
      FST_RD_IDLE: begin
        if (start_fuse) begin
          next_rd_state  = FST_RD_SETUP;
          next_rd_cnt    = setup_cnt;
          next_fuse_addr = {avm_req_i.address[5:2], lane};
          next_fuse_fuse_read_enable = 1'b1;
        end
      end
      FST_RD_SETUP: begin
        if (rd_cnt == 8'h00) begin
          next_rd_state  = FST_RD_STROBE;
          next_rd_cnt    = strobe_cnt;
          next_fuse_strb = 1'b1;
        end else begin
          next_rd_cnt = rd_cnt - 8'h01;
        end
      end
      FST_RD_STROBE: begin
        if (rd_cnt == 8'h00) begin
          next_rd_state  = FST_RD_HOLD;
          next_rd_cnt    = hold_cnt;
          next_fuse_strb = 1'b0;
          next_read_data = fuse_dout_i;
        end else begin
          next_rd_cnt = rd_cnt - 8'h01;
        end
      end
      FST_RD_HOLD: begin
        if (rd_cnt == 8'h00) begin
          next_rd_state  = FST_RD_DONE;
          next_fuse_fuse_read_enable = 1'b0;
        end else begin
          next_rd_cnt = rd_cnt - 8'h01;
        end
      end
      FST_RD_DONE: begin
        next_rd_state = FST_RD_IDLE;
      end
      default: begin
        next_rd_state  = FST_RD_IDLE;
        next_fuse_fuse_read_enable = 1'b0;
        next_fuse_strb = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_state  <= FST_RD_IDLE;
      rd_cnt    <= 8'h00;
      fuse_addr <= 6'h00;
      fuse_fuse_read_enable <= 1'b0;
      fuse_strb <= 1'b0;
      read_data <= 8'h00;
    end else begin
      rd_state  <= next_rd_state;
      rd_cnt    <= next_rd_cnt;
      fuse_addr <= next_fuse_addr;
      fuse_fuse_read_enable <= next_fuse_fuse_read_enable;
      fuse_strb <= next_fuse_strb;
      read_data <= next_read_data;
    end
  end

  assign fuse_req_o = '{fuse_addr: fuse_addr, fuse_read_enable: fuse_fuse_read_enable, fuse_strobe: fuse_strb};

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    next_strobe_cnt   = strobe_cnt;
    next_hold_cnt     = hold_cnt;
    next_setup_cnt    = setup_cnt;
    next_key_state    = key_state;
    next_thr          = thr;
    next_det_en       = det_en;
    next_irq_en       = irq_en;
    next_rst_en       = rst_en;
    next_out_en       = out_en;
    next_por_en       = por_en;
    next_load_pending = 1'b0;
    if (load_pending && !fuse_dflt_i.erased) begin
      next_thr    = fuse_dflt_i.threshold;
      next_rst_en = fuse_dflt_i.reset_enable;
      next_por_en = fuse_dflt_i.por_enable;
    end
    if (wr_ok && avm_req_i.address == FST_OFS_TIMING) begin
      if (avm_req_i.byteenable[0]) next_strobe_cnt = avm_req_i.writedata[FST_TIM_STROBE_LSB +: 8];
      if (avm_req_i.byteenable[1]) next_hold_cnt   = avm_req_i.writedata[FST_TIM_HOLD_LSB +: 8];
      if (avm_req_i.byteenable[2]) next_setup_cnt  = avm_req_i.writedata[FST_TIM_SETUP_LSB +: 8];
    end
    if (wr_ok && avm_req_i.address == FST_OFS_SUPPLY) begin
      if (key_state == FST_KEY_UNLOCK) begin
        if (avm_req_i.byteenable[0]) begin
          next_thr    = avm_req_i.writedata[FST_CFG_THR_LSB +: 2];
          next_det_en = avm_req_i.writedata[FST_CFG_DET_EN];
          next_irq_en = avm_req_i.writedata[FST_CFG_IRQ_EN];
          next_rst_en = avm_req_i.writedata[FST_CFG_RST_EN];
          next_out_en = avm_req_i.writedata[FST_CFG_OUT_EN];
        end
        if (avm_req_i.byteenable[1]) next_por_en = avm_req_i.writedata[FST_CFG_POR_EN];
      end
      if (avm_req_i.byteenable[0]) begin
        case (key_state)
          FST_KEY_LOCKED: next_key_state = (key_wr == FST_KEY_STEP1) ? FST_KEY_SAW1 : FST_KEY_LOCKED;
          FST_KEY_SAW1: begin
            if (key_wr == FST_KEY_STEP2)      next_key_state = FST_KEY_SAW2;
            else if (key_wr != FST_KEY_STEP1) next_key_state = FST_KEY_LOCKED;
          end
          FST_KEY_SAW2: begin
            if (key_wr == FST_KEY_OPEN)       next_key_state = FST_KEY_UNLOCK;
            else if (key_wr == FST_KEY_STEP1) next_key_state = FST_KEY_SAW1;
            else                              next_key_state = FST_KEY_LOCKED;
          end
          FST_KEY_UNLOCK: begin
            if (key_wr == FST_KEY_RELOCK) next_key_state = FST_KEY_LOCKED;
          end
          default: next_key_state = FST_KEY_LOCKED;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      strobe_cnt   <= FST_COUNT_RST;
      hold_cnt     <= FST_COUNT_RST;
      setup_cnt    <= FST_COUNT_RST;
      key_state    <= FST_KEY_LOCKED;
      thr          <= 2'h0;
      det_en       <= 1'b0;
      irq_en       <= 1'b0;
      rst_en       <= 1'b0;
      out_en       <= 1'b0;
      por_en       <= 1'b0;
      load_pending <= 1'b1;
    end else begin
      strobe_cnt   <= next_strobe_cnt;
      hold_cnt     <= next_hold_cnt;
      setup_cnt    <= next_setup_cnt;
      key_state    <= next_key_state;
      thr          <= next_thr;
      det_en       <= next_det_en;
      irq_en       <= next_irq_en;
      rst_en       <= next_rst_en;
      out_en       <= next_out_en;
      por_en       <= next_por_en;
      load_pending <= next_load_pending;
    end
  end

  // ----------------------------------------------------------------
  // supply monitor
  // ----------------------------------------------------------------
  always_comb begin
    next_flag    = flag | (det_en & below_s);
    next_det_out = det_en & below_s;
    next_irq     = det_en & irq_en & below_s;
    next_por_req = det_en & por_en & below_s;
    next_rst_req = det_en & rst_en & ~por_en & below_s;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag    <= 1'b0;
      det_out <= 1'b0;
      irq     <= 1'b0;
      por_req <= 1'b0;
      rst_req <= 1'b0;
    end else begin
      flag    <= next_flag;
      det_out <= next_det_out;
      irq     <= next_irq;
      por_req <= next_por_req;
      rst_req <= next_rst_req;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_level
      assign threshold_level_o[g] = det_en && (thr == 2'(g));
    end
  endgenerate

  assign threshold_sel_o        = thr;
  assign detector_enable_o      = det_en;
  assign detector_out_o         = det_out & out_en;
  assign detector_out_oe_o      = out_en;
  assign low_supply_irq_o       = irq;
  assign por_request_o          = por_req;
  assign supply_reset_request_o = rst_req;

endmodule : fst_ctrl

// ---- fst_ctrl_monitor.sv ----
/*
  port checker for fst_ctrl: fuse read timing, bus answers and supply outputs.
  assumes it is bound into every fst_ctrl instance.
*/
`timescale 1ns/100ps
module fst_ctrl_monitor (
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  input wire fst_pkg::fst_avm_req_t  avm_req_i,
  input wire logic                   supervisor_i,
  input wire fst_pkg::fst_avm_rsp_t  avm_rsp_o,
  input wire fst_pkg::fst_fuse_req_t fuse_req_o,
  input wire logic [7:0]             fuse_dout_i,
  input wire logic [1:0]             threshold_sel_o,
  input wire logic [3:0]             threshold_level_o,
  input wire logic                   detector_enable_o,
  input wire logic                   detector_out_o,
  input wire logic                   detector_out_oe_o,
  input wire logic                   low_supply_irq_o,
  input wire logic                   por_request_o,
  input wire logic                   supply_reset_request_o
);
  import fst_pkg::*;
  // ----------------------------------------------------------------
  // shadow of the timing counts and phase counters
  // ----------------------------------------------------------------
  logic [7:0] sw, hw, su, cap;
  logic [8:0] scnt, ucnt;
  logic       stb, ren, acc;
  assign stb = fuse_req_o.fuse_strobe;
  assign ren = fuse_req_o.fuse_read_enable;
  assign acc = avm_req_i.write && !avm_rsp_o.waitrequest && supervisor_i && avm_req_i.address == FST_OFS_TIMING;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sw   <= FST_COUNT_RST;
      hw   <= FST_COUNT_RST;
      su   <= FST_COUNT_RST;
      scnt <= 9'h0;
      ucnt <= 9'h0;
      cap  <= 8'h0;
    end else begin
      if (acc && avm_req_i.byteenable[0]) sw <= avm_req_i.writedata[7:0];
      if (acc && avm_req_i.byteenable[1]) hw <= avm_req_i.writedata[15:8];
      if (acc && avm_req_i.byteenable[2]) su <= avm_req_i.writedata[23:16];
      scnt <= stb ? scnt + 9'h1 : 9'h0;
      ucnt <= stb ? 9'h0 : (ren ? ucnt + 9'h1 : 9'h0);
      if (stb) cap <= fuse_dout_i;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ans;
    (avm_req_i.read || avm_req_i.write) && !avm_rsp_o.waitrequest;
  endsequence
  sequence s_win;
    avm_req_i.read && supervisor_i && avm_req_i.address[7:6] == FST_WIN_TAG;
  endsequence
  strobe_width_a: assert property ($fell(stb) |-> scnt == sw + 9'h1)
    else $error("strobe width wrong");
  setup_time_a: assert property ($rose(stb) |-> ucnt == su + 9'h1)
    else $error("setup time wrong");
  hold_time_a: assert property ($fell(ren) |-> ucnt == hw + 9'h1)
    else $error("hold time wrong");
  addr_stable_a: assert property (ren && $past(ren) |-> $stable(fuse_req_o.fuse_addr))
    else $error("fuse address moved");
  strobe_qual_a: assert property (stb |-> ren)
    else $error("strobe without read enable");
  fuse_byte_a: assert property (s_win ##0 s_ans |-> avm_rsp_o.readdata[7:0] == cap)
    else $error("fuse byte not returned");
  user_error_a: assert property (s_ans ##0 !supervisor_i |-> avm_rsp_o.response == FST_RESP_SLVERR
    && avm_rsp_o.readdata == 32'h0)
    else $error("user access not refused");
  super_okay_a: assert property (s_ans ##0 supervisor_i |-> avm_rsp_o.response == FST_RESP_OKAY)
    else $error("supervisor access got error");
  unmapped_zero_a: assert property (s_ans ##0 (avm_req_i.read && avm_req_i.address[7:6] == 2'h1)
    |-> avm_rsp_o.readdata == 32'h0)
    else $error("reserved read not zero");
  level_decode_a: assert property (threshold_level_o ==
    (detector_enable_o ? 4'(4'h1 << threshold_sel_o) : 4'h0))
    else $error("threshold level decode wrong");
  out_gate_a: assert property (!detector_out_oe_o && !$past(detector_out_oe_o) |-> !detector_out_o)
    else $error("detector output driven while disabled");
  det_off_quiet_a: assert property (!detector_enable_o && !$past(detector_enable_o)
    |-> !(low_supply_irq_o || por_request_o || supply_reset_request_o))
    else $error("detector event while disabled");
endmodule : fst_ctrl_monitor

bind fst_ctrl fst_ctrl_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avm_req_i(avm_req_i),
  .supervisor_i(supervisor_i), .avm_rsp_o(avm_rsp_o), .fuse_req_o(fuse_req_o), .fuse_dout_i(fuse_dout_i),
  .threshold_sel_o(threshold_sel_o), .threshold_level_o(threshold_level_o),
  .detector_enable_o(detector_enable_o), .detector_out_o(detector_out_o),
  .detector_out_oe_o(detector_out_oe_o), .low_supply_irq_o(low_supply_irq_o),
  .por_request_o(por_request_o), .supply_reset_request_o(supply_reset_request_o));

// ---- fst_fuse_model.sv ----
/*
  behavioural fuse array standing on the far side of fst_ctrl.
  assumes fuse_req_i comes from registers on clk_i.
*/
`timescale 1ns/100ps
module fst_fuse_model (
  input  wire logic                   clk_i,
  input  wire fst_pkg::fst_fuse_req_t fuse_req_i,
  output logic [7:0]                  fuse_dout_o
);
  import fst_pkg::*;
  logic [7:0] mem [64];
  logic [7:0] last = 8'h00;
  logic       rd;
  initial for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5a;
  assign rd = fuse_req_i.fuse_strobe && fuse_req_i.fuse_read_enable;
  // byte read in one go; outside a strobe the lines toggle
  assign fuse_dout_o = rd ? mem[fuse_req_i.fuse_addr] : ~last;
  always @(posedge clk_i) last <= fuse_dout_o;
endmodule : fst_fuse_model

// ---- fst_ctrl_tb.sv ----
/*
  self-checking bench for fst_ctrl with a fuse array model.
  assumes fst_ctrl_monitor is bound in by its own file.
*/
`timescale 1ns/100ps
module fst_ctrl_tb;
  import fst_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, sup = 1'b0, below = 1'b0;
  fst_avm_req_t   req = '0;
  fst_avm_rsp_t   rsp;
  fst_fuse_req_t  freq;
  fst_fuse_dflt_t dflt = 5'b01011;
  logic [7:0]  fdout;
  logic [1:0]  thr, rrsp;
  logic [3:0]  lvl;
  logic        den, dout, doe, irq, por, srr;
  logic [31:0] rdat;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  fst_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avm_req_i(req), .supervisor_i(sup),
    .avm_rsp_o(rsp), .fuse_req_o(freq), .fuse_dout_i(fdout), .fuse_dflt_i(dflt),
    .monitored_supply_below_i(below), .threshold_sel_o(thr), .threshold_level_o(lvl),
    .detector_enable_o(den), .detector_out_o(dout), .detector_out_oe_o(doe), .low_supply_irq_o(irq),
    .por_request_o(por), .supply_reset_request_o(srr));
  fst_fuse_model u_fuse (.clk_i(clk_i), .fuse_req_i(freq), .fuse_dout_o(fdout));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic r, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be, input logic s);
    int k;
    k = 0;
    @(posedge clk_i);
    req.read <= r;
    req.write <= !r;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= be;
    sup <= s;
    @(posedge clk_i);
    while (rsp.waitrequest !== 1'b0 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 300) chk(32'h1, 32'h0);
    rdat = rsp.readdata;
    rrsp = rsp.response;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (s) chk(32'(rrsp), 32'(FST_RESP_OKAY));
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'hf, 1'b1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] e);
    bus(1'b1, a, 32'h0, be, 1'b1);
    chk(rdat, e);
  endtask : rd
  task do_reset;
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset
  task settle;
    repeat (6) @(posedge clk_i);
  endtask : settle
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_defaults;
    rd(8'h00, 4'hf, 32'h00040404);
    rd(8'h1c, 4'h3, 32'h00000112);
    dflt.erased <= 1'b1;
    do_reset();
    rd(8'h1c, 4'h3, 32'h00000000);
    dflt.erased <= 1'b0;
    do_reset();
    $display("test defaults done");
  endtask : t_defaults
  task t_fuse;
    logic [31:0] cw [2];
    logic [7:0]  b;
    logic [3:0]  be;
    cw[0] = 32'hff020301;
    cw[1] = 32'h00000000;
    rd(8'h84, 4'h2, {4{8'h5f}});
    rd(8'h84, 4'hf, {4{8'h5e}});
    for (int p = 0; p < 2; p++) begin
      wr(8'h00, cw[p]);
      rd(8'h00, 4'hf, cw[p] & 32'h00ffffff);
      for (int i = 0; i < 64; i += 7) begin
        b = 8'(i) ^ 8'h5a;
        be = 4'(1 << (i % 4));
        rd(8'h80 | 8'(i & 60), be, {4{b}});
      end
    end
    $display("test fuse done");
  endtask : t_fuse
  task t_access;
    bus(1'b0, 8'h00, 32'h00111111, 4'hf, 1'b0);
    chk(32'(rrsp), 32'(FST_RESP_SLVERR));
    bus(1'b1, 8'h00, 32'h0, 4'hf, 1'b0);
    chk(rdat, 32'h0);
    chk(32'(rrsp), 32'(FST_RESP_SLVERR));
    rd(8'h00, 4'hf, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 4'hf, 32'h0);
    $display("test access done");
  endtask : t_access
  task t_key;
    wr(8'h1c, 32'h0000003d);
    rd(8'h1c, 4'h3, 32'h00000112);
    wr(8'h1c, 32'h00000040);
    wr(8'h1c, 32'h000000c0);
    rd(8'h1c, 4'h3, 32'h00000112);
    wr(8'h1c, 32'h00000040);
    wr(8'h1c, 32'h00000080);
    wr(8'h1c, 32'h000000c0);
    rd(8'h1c, 4'h3, 32'h000001d2);
    wr(8'h1c, 32'h0000807d);
    rd(8'h1c, 4'h3, 32'h000000fd);
    $display("test key done");
  endtask : t_key
  task t_supply;
    chk(32'(lvl), 32'h2);
    chk(32'(den), 32'h1);
    below <= 1'b1;
    settle();
    chk(32'(irq), 32'h1);
    chk({srr, por}, 32'h2);
    chk({dout, doe}, 32'h3);
    rd(8'h1c, 4'h3, 32'h000080fd);
    below <= 1'b0;
    settle();
    rd(8'h1c, 4'h3, 32'h000080fd);
    wr(8'h1c, 32'h000001f5);
    below <= 1'b1;
    settle();
    chk({srr, por}, 32'h1);
    chk(32'(irq), 32'h0);
    for (int t = 0; t < 4; t++) begin
      wr(8'h1c, 32'h000001f4 | t);
      @(posedge clk_i);
      chk({thr, lvl}, 32'(t * 16 + (1 << t)));
    end
    wr(8'h1c, 32'h000001d5);
    settle();
    chk({dout, doe}, 32'h0);
    wr(8'h1c, 32'h00000015);
    rd(8'h1c, 4'h3, 32'h00008015);
    wr(8'h1c, 32'h00000000);
    rd(8'h1c, 4'h3, 32'h00008015);
    below <= 1'b0;
    do_reset();
    rd(8'h1c, 4'h3, 32'h00000112);
    chk(32'(den), 32'h0);
    $display("test supply done");
  endtask : t_supply
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_defaults();
    t_fuse();
    t_access();
    t_key();
    t_supply();
    print_verdict();
  end
endmodule : fst_ctrl_tb
